// file: vic_pkg.sv
// Constants and carrier types of the vectored interrupt controller
// ****************************************************************
// Notes on behaviour
// [RULE1] Two active-low requests to the core: normal request and fast request.
// [RULE2] Thirty-two sources, each with its own enable and its own vector.
// [RULE3] Source 0 is the fast pin and feeds only the fast request.
// [RULE4] Source 1 carries the combined system-peripheral line.
// [RULE5] Source 1 is the OR of the seven system-peripheral request lines.
// [RULE6] Each internal source is set to edge-triggered or level-sensitive.
// [RULE7] External sources: rising, falling, high-level or low-level sensitive.
// [RULE8] Three external request pins exist besides the fast pin.
// [RULE9] External pins sit at sources 29, 30 and 31.
// [RULE10] An eight-level arbiter ranks enabled pending sources 1 to 31.
// [RULE11] Only the arbiter drives the normal request output.
// [RULE12] A strictly higher priority source may raise the request during service.
// [RULE13] One 32-bit programmable vector is held per source.
// [RULE14] A vector read returns the vector of the signalled source.
// [RULE15] In protect mode reads cause no acknowledge or level change.
// [RULE16] Fast forcing moves any normal source onto the fast request.
// [RULE17] Source numbers follow peripheral numbers; 15 and 16 are reserved.
// [RULE18] A stack holds active levels; end-of-service pops back to previous.
// ****************************************************************
package vic_pkg;

  localparam int NUM_SRC = 32;
  localparam int SRC_W = 5;
  localparam int PRIO_W = 3;
  localparam int VEC_W = 32;
  localparam int STACK_DEPTH = 8;
  localparam int DEPTH_W = 4;
  localparam int SYS_LINES = 7;

  // Fixed source numbers
  localparam int SRC_FAST = 0;
  localparam int SRC_SYS = 1;
  localparam int SRC_PERIPH_LO = 2;
  localparam int SRC_PERIPH_HI = 28;
  localparam int SRC_RSV_A = 15;
  localparam int SRC_RSV_B = 16;
  localparam int SRC_EXT_ZERO = 29;
  localparam int SRC_EXT_ONE = 30;
  localparam int SRC_EXT_TWO = 31;

  // Reset values and the full-stack depth
  localparam logic [VEC_W-1:0] SPURIOUS_VEC = 32'h0000_0000;
  localparam logic [VEC_W-1:0] VEC_RESET = 32'h0000_0000;
  localparam logic [DEPTH_W-1:0] DEPTH_RESET = 4'h0;
  localparam logic [DEPTH_W-1:0] DEPTH_FULL = 4'h8;

  // System-peripheral lines folded into source 1
  typedef struct packed {
    logic dram_ctrl;
    logic debug_uart_unit;
    logic periodic_tick_timer;
    logic realtime_tick_timer;
    logic watchdog;
    logic reset_ctrl;
    logic power_clock_manager;
  } vic_sys_lines_type;

  // Vector programming strobe
  typedef struct packed {
    logic en;
    logic [SRC_W-1:0] src;
    logic [VEC_W-1:0] data;
  } vic_vec_wr_type;

  typedef logic [NUM_SRC-1:0][PRIO_W-1:0] vic_prio_array_type;

endpackage

// file: vic_vectored_irq_controller.sv
// Vectored, prioritised interrupt controller with nesting stack
`timescale 1ns/1ps

module vic_vectored_irq_controller (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // Interrupt sources
  input wire vic_pkg::vic_sys_lines_type i_sys_lines,
  input wire logic [vic_pkg::SRC_PERIPH_HI:vic_pkg::SRC_PERIPH_LO] i_periph_irq,
  input wire logic i_fast_request_pin,
  input wire logic i_ext_request_zero,
  input wire logic i_ext_request_one,
  input wire logic i_ext_request_two,
  // Per-source configuration and protect mode
  input wire logic [vic_pkg::NUM_SRC-1:0] i_src_enable,
  input wire logic [vic_pkg::NUM_SRC-1:0] i_edge_mode,
  input wire logic [vic_pkg::NUM_SRC-1:0] i_polarity,
  input wire logic [vic_pkg::NUM_SRC-1:0] i_fast_force,
  input wire vic_pkg::vic_prio_array_type i_src_prio,
  input wire logic i_protect,
  input wire vic_pkg::vic_vec_wr_type i_vec_wr,
  // Service handshake
  input wire logic i_vec_rd,
  input wire logic i_ack_wr,
  input wire logic i_eoi,
  input wire logic i_fast_clr,
  // Core requests
  output logic o_normal_request_n,
  output logic o_fast_request_n,
  // Vector read and status
  output logic [vic_pkg::VEC_W-1:0] o_vec_rdata,
  output logic o_vec_rvalid,
  output logic [vic_pkg::SRC_W-1:0] o_cur_src,
  output logic [vic_pkg::PRIO_W-1:0] o_cur_prio,
  output logic [vic_pkg::DEPTH_W-1:0] o_nest_depth,
  output logic [vic_pkg::NUM_SRC-1:0] o_pending
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  function automatic logic is_ext(input int idx);
    is_ext = (idx == vic_pkg::SRC_FAST) || (idx == vic_pkg::SRC_EXT_ZERO) ||
             (idx == vic_pkg::SRC_EXT_ONE) || (idx == vic_pkg::SRC_EXT_TWO);
  endfunction

  // Highest priority wins; ties go to the lowest source number
  function automatic logic [vic_pkg::SRC_W+vic_pkg::PRIO_W:0] pick_best(
    input logic [vic_pkg::NUM_SRC-1:0] cand,
    input vic_pkg::vic_prio_array_type prio
  );
    logic found;
    logic [vic_pkg::SRC_W-1:0] src;
    logic [vic_pkg::PRIO_W-1:0] lvl;
    found = 1'b0;
    src = '0;
    lvl = '0;
    for (int i = vic_pkg::NUM_SRC - 1; i >= 1; i--) begin
      if (cand[i] && (!found || prio[i] >= lvl)) begin
        found = 1'b1;
        src = i[vic_pkg::SRC_W-1:0];
        lvl = prio[i];
      end
    end
    pick_best = {found, src, lvl};
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************

  logic [3:0] ext_meta_q;
  logic [3:0] ext_sync_q;
  wire [3:0] ext_pins = {i_ext_request_two, i_ext_request_one,
                         i_ext_request_zero, i_fast_request_pin};

  // No reset: pins flush through during reset, so release shows their level
  always_ff @(posedge i_clk_sys) begin
    ext_meta_q <= ext_pins;
    ext_sync_q <= ext_meta_q;
  end

  // ****************************************************************
  // Source assembly and trigger conditioning
  // ****************************************************************

  logic [vic_pkg::NUM_SRC-1:0] raw_src;
  logic [vic_pkg::NUM_SRC-1:0] norm_src;
  logic [vic_pkg::NUM_SRC-1:0] prev_q;
  logic [vic_pkg::NUM_SRC-1:0] pend_q;
  logic [vic_pkg::NUM_SRC-1:0] pend_d;
  logic [vic_pkg::NUM_SRC-1:0] pending;
  logic [vic_pkg::NUM_SRC-1:0] clr;
  logic [vic_pkg::NUM_SRC-1:0] fast_route;
  logic [vic_pkg::NUM_SRC-1:0] active;
  logic [vic_pkg::NUM_SRC-1:0] normal_cand;

  assign raw_src[vic_pkg::SRC_FAST] = ext_sync_q[0]; // [RULE3]
  assign raw_src[vic_pkg::SRC_SYS] = |i_sys_lines; // [RULE4] [RULE5]
  assign raw_src[vic_pkg::SRC_EXT_TWO:vic_pkg::SRC_EXT_ZERO] =
    ext_sync_q[3:1]; // [RULE8] [RULE9]

  genvar g;
  generate
    for (g = vic_pkg::SRC_PERIPH_LO; g <= vic_pkg::SRC_PERIPH_HI;
         g++) begin : g_periph
      // Reserved numbers never raise a request
      if (g == vic_pkg::SRC_RSV_A || g == vic_pkg::SRC_RSV_B) begin : g_rsv
        assign raw_src[g] = 1'b0; // [RULE17]
      end else begin : g_used
        assign raw_src[g] = i_periph_irq[g]; // [RULE17]
      end
    end

    for (g = 0; g < vic_pkg::NUM_SRC; g++) begin : g_src
      // Polarity only applies to pins; internal lines are active high
      if (is_ext(g)) begin : g_ext
        assign norm_src[g] = raw_src[g] ^ ~i_polarity[g]; // [RULE7]
      end else begin : g_int
        assign norm_src[g] = raw_src[g];
      end
      // Edge latch: a new edge beats a same-cycle clear
      assign pend_d[g] = (pend_q[g] & ~clr[g]) |
                         (norm_src[g] & ~prev_q[g]); // [RULE6]
      assign pending[g] = i_edge_mode[g] ? pend_q[g] : norm_src[g]; // [RULE6]
    end
  endgenerate

  // ****************************************************************
  // Routing and arbitration
  // ****************************************************************

  logic [vic_pkg::DEPTH_W-1:0] depth_q;
  logic [vic_pkg::PRIO_W-1:0] stk_prio_q [vic_pkg::STACK_DEPTH];
  logic [vic_pkg::SRC_W-1:0] stk_src_q [vic_pkg::STACK_DEPTH];
  logic [vic_pkg::VEC_W-1:0] vec_q [vic_pkg::NUM_SRC];

  wire [vic_pkg::SRC_W+vic_pkg::PRIO_W:0] best;
  wire best_found;
  wire [vic_pkg::SRC_W-1:0] best_src;
  wire [vic_pkg::PRIO_W-1:0] best_prio;
  wire [vic_pkg::PRIO_W-1:0] top_idx;
  wire [vic_pkg::PRIO_W-1:0] top_prio;
  wire stack_empty;
  wire stack_full;
  wire can_nest;
  wire ack_fire;
  wire pop_fire;
  wire fast_any;

  assign fast_route = i_fast_force |
                      {{(vic_pkg::NUM_SRC-1){1'b0}}, 1'b1}; // [RULE3] [RULE16]
  assign active = pending & i_src_enable; // [RULE2]
  assign normal_cand = active & ~fast_route; // [RULE10] [RULE16]
  assign fast_any = |(active & fast_route); // [RULE16]

  assign best = pick_best(normal_cand, i_src_prio); // [RULE10]
  assign best_found = best[vic_pkg::SRC_W+vic_pkg::PRIO_W];
  assign best_src = best[vic_pkg::SRC_W+vic_pkg::PRIO_W-1:vic_pkg::PRIO_W];
  assign best_prio = best[vic_pkg::PRIO_W-1:0];

  assign stack_empty = (depth_q == vic_pkg::DEPTH_RESET);
  assign stack_full = (depth_q == vic_pkg::DEPTH_FULL);
  assign top_idx = 3'(depth_q - 4'h1);
  assign top_prio = stk_prio_q[top_idx];

  // Nesting only for strictly higher levels
  assign can_nest = best_found && !stack_full &&
                    (stack_empty || best_prio > top_prio); // [RULE12]
  // Reads acknowledge only outside protect mode
  assign ack_fire = can_nest &&
                    (i_protect ? i_ack_wr : i_vec_rd); // [RULE15]
  assign pop_fire = i_eoi && !stack_empty && !ack_fire; // [RULE18]

  always_comb begin
    for (int i = 0; i < vic_pkg::NUM_SRC; i++) begin
      clr[i] = (ack_fire && best_src == i[vic_pkg::SRC_W-1:0]) ||
               (i_fast_clr && fast_route[i]);
    end
  end

  // ****************************************************************
  // Source state
  // ****************************************************************

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      pend_q <= '0;
    end else begin
      pend_q <= pend_d;
    end
  end

  // History tracks sources through reset, so release is never an edge
  always_ff @(posedge i_clk_sys) begin
    prev_q <= norm_src; // [RULE6]
  end

  // Vector store; no reset on the array keeps it a plain memory
  always_ff @(posedge i_clk_sys) begin
    if (i_vec_wr.en) begin
      vec_q[i_vec_wr.src] <= i_vec_wr.data; // [RULE13]
    end
  end

  // ****************************************************************
  // Priority stack
  // ****************************************************************

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      depth_q <= vic_pkg::DEPTH_RESET;
    end else if (ack_fire) begin
      depth_q <= depth_q + 4'h1; // [RULE18]
    end else if (pop_fire) begin
      depth_q <= depth_q - 4'h1; // [RULE18]
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (ack_fire) begin
      stk_prio_q[depth_q[vic_pkg::PRIO_W-1:0]] <= best_prio;
      stk_src_q[depth_q[vic_pkg::PRIO_W-1:0]] <= best_src;
    end
  end

  // ****************************************************************
  // Output registers
  // ****************************************************************

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_normal_request_n <= 1'b1;
      o_fast_request_n <= 1'b1;
      o_vec_rdata <= vic_pkg::SPURIOUS_VEC;
      o_vec_rvalid <= 1'b0;
      o_pending <= '0;
    end else begin
      o_normal_request_n <= ~can_nest; // [RULE1] [RULE11]
      o_fast_request_n <= ~fast_any; // [RULE1] [RULE16]
      o_vec_rvalid <= i_vec_rd;
      o_pending <= pending;
      if (i_vec_rd) begin
        o_vec_rdata <= can_nest ? vec_q[best_src]
                                : vic_pkg::SPURIOUS_VEC; // [RULE14]
      end
    end
  end

  // Status mirrors the stack top after each push or pop
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_cur_src <= '0;
      o_cur_prio <= '0;
      o_nest_depth <= vic_pkg::DEPTH_RESET;
    end else if (ack_fire) begin
      o_cur_src <= best_src;
      o_cur_prio <= best_prio;
      o_nest_depth <= depth_q + 4'h1;
    end else if (pop_fire) begin
      o_cur_src <= (depth_q == 4'h1) ? '0 : stk_src_q[3'(depth_q - 4'h2)];
      o_cur_prio <= (depth_q == 4'h1) ? '0 : stk_prio_q[3'(depth_q - 4'h2)];
      o_nest_depth <= depth_q - 4'h1;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_srst);

  normal_idle_a: assert property ( // [RULE11]
    !can_nest |=> o_normal_request_n)
    else $error("normal request low without a winning source");

  fast_pin_a: assert property ( // [RULE3]
    active[vic_pkg::SRC_FAST] |=> !o_fast_request_n && !normal_cand[0])
    else $error("fast pin did not raise the fast request");

  fast_force_a: assert property ( // [RULE16]
    (|(active & i_fast_force)) |->
      !(|(normal_cand & i_fast_force)) ##1 !o_fast_request_n)
    else $error("forced source not routed to fast request");

  vector_read_a: assert property ( // [RULE14]
    (i_vec_rd && can_nest) |=> o_vec_rvalid &&
      o_vec_rdata == vec_q[$past(best_src)])
    else $error("vector read returned the wrong vector");

  protect_read_a: assert property ( // [RULE15]
    (i_protect && i_vec_rd && !i_ack_wr && !i_eoi) |=>
      depth_q == $past(depth_q))
    else $error("protected read changed the level stack");

  nest_push_a: assert property ( // [RULE12]
    ack_fire |=> depth_q == $past(depth_q) + 4'h1 &&
      o_cur_prio == $past(best_prio) && o_cur_src == $past(best_src))
    else $error("acknowledge did not push the new level");

  eoi_pop_a: assert property ( // [RULE18]
    pop_fire |=> depth_q == $past(depth_q) - 4'h1)
    else $error("end of service did not pop the level");

  lower_blocked_a: assert property ( // [RULE10]
    (!stack_empty && best_found && best_prio <= top_prio) |=>
      o_normal_request_n)
    else $error("equal or lower level raised the normal request");

  reserved_quiet_a: assert property ( // [RULE17]
    !pending[vic_pkg::SRC_RSV_A] && !pending[vic_pkg::SRC_RSV_B])
    else $error("reserved source became pending");

  sys_line_a: assert property ( // [RULE5]
    ((|i_sys_lines) && i_src_enable[1] && !i_edge_mode[1] &&
      !i_fast_force[1]) |-> normal_cand[1])
    else $error("system line did not reach source 1");

  ext_edge_a: assert property ( // [RULE7]
    (i_edge_mode[29] && norm_src[29] && !prev_q[29]) |=> pend_q[29])
    else $error("external edge was not latched");

  edge_hold_a: assert property ( // [RULE6]
    (i_edge_mode[9] && pend_q[9] && !clr[9]) |=> pend_q[9])
    else $error("edge pending dropped without a clear");

  nest_two_c: cover property (ack_fire ##[1:20] ack_fire);
  fast_req_c: cover property (!o_fast_request_n ##1 i_fast_clr);
  protect_ack_c: cover property (i_protect && i_ack_wr && can_nest);
  eoi_back_c: cover property (ack_fire ##[1:20] pop_fire);

endmodule

// file: vic_core_model.sv
// Core model that answers the normal request with a vector read
`timescale 1ns/1ps

module vic_core_model (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // Behaviour control
  input wire logic i_serve,
  input wire logic i_slow,
  // Request from the controller
  input wire logic i_normal_request_n,
  // Answer
  output logic o_vec_rd
);
  logic [1:0] phase_q;
  logic [3:0] wait_q;
  // *****************
  // Service sequencer
  // *****************
  always_ff @(posedge i_clk_sys) begin
    o_vec_rd <= 1'b0;
    if (i_srst) begin
      phase_q <= 2'h0;
      wait_q <= 4'h0;
    end else if (wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
    end else if (phase_q == 2'h1) begin
      o_vec_rd <= 1'b1;
      phase_q <= 2'h2;
      wait_q <= 4'h4;
    end else if (phase_q == 2'h2) begin
      phase_q <= 2'h0;
    end else if (i_serve && !i_normal_request_n) begin
      phase_q <= 2'h1;
      // Slow core leaves the request standing
      wait_q <= i_slow ? 4'h9 : 4'h0;
    end
  end
endmodule

// file: tb_vic_vectored_irq_controller.sv
// Self-checking bench of the vectored interrupt controller
`timescale 1ns/1ps

module tb_vic_vectored_irq_controller;
  logic i_clk_sys = 1'b0;
  logic i_srst = 1'b1;
  vic_pkg::vic_sys_lines_type sys = 7'h0;
  vic_pkg::vic_vec_wr_type vwr = 38'h0;
  vic_pkg::vic_prio_array_type prio = 96'h0;
  logic [28:2] per = 27'h0;
  logic [2:0] ext = 3'h0;
  logic [31:0] en = 32'hffff_ffff;
  logic [31:0] edg = 32'h0000_0080;
  logic [31:0] pol = 32'hffff_ffff;
  logic [31:0] ff = 32'h0;
  logic fpin = 1'b0;
  logic prot = 1'b0;
  logic rd = 1'b0;
  logic eoi = 1'b0;
  logic ack = 1'b0;
  logic fclr = 1'b0;
  logic serve = 1'b0;
  logic slow = 1'b0;
  logic core_rd;
  logic norm_n;
  logic fast_n;
  logic rvalid;
  logic [31:0] rdata;
  logic [31:0] pend;
  logic [4:0] csrc;
  logic [2:0] cprio;
  logic [3:0] depth;
  logic [31:0] vec [32];
  logic [31:0] exp_q [$];
  logic [31:0] seed = 32'hfc3a;
  int num_errors = 0;
  int cmp_count = 0;

  always #5 i_clk_sys = ~i_clk_sys;

  vic_vectored_irq_controller dut (
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_sys_lines(sys),
    .i_periph_irq(per), .i_fast_request_pin(fpin),
    .i_ext_request_zero(ext[0]), .i_ext_request_one(ext[1]),
    .i_ext_request_two(ext[2]), .i_src_enable(en), .i_edge_mode(edg),
    .i_polarity(pol), .i_fast_force(ff), .i_src_prio(prio),
    .i_protect(prot), .i_vec_wr(vwr), .i_vec_rd(rd | core_rd),
    .i_ack_wr(ack), .i_eoi(eoi), .i_fast_clr(fclr),
    .o_normal_request_n(norm_n), .o_fast_request_n(fast_n),
    .o_vec_rdata(rdata), .o_vec_rvalid(rvalid), .o_cur_src(csrc),
    .o_cur_prio(cprio), .o_nest_depth(depth), .o_pending(pend));

  vic_core_model core (
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_serve(serve),
    .i_slow(slow), .i_normal_request_n(norm_n), .o_vec_rd(core_rd));

  // ****************
  // Helpers
  // ****************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rst();
    repeat (4) @(posedge i_clk_sys) i_srst <= 1'b1;
    @(posedge i_clk_sys) i_srst <= 1'b0;
  endtask

  task automatic rdv(input logic [31:0] e);
    @(posedge i_clk_sys) rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge i_clk_sys) rd <= 1'b0;
  endtask

  task automatic end_service();
    @(posedge i_clk_sys) eoi <= 1'b1;
    @(posedge i_clk_sys) eoi <= 1'b0;
  endtask

  task automatic summarize();
    $display("comparisons %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Read data monitor, oldest note first
  always @(negedge i_clk_sys) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0)
        chk("rvalid", 32'h0, 32'h1);
      else
        chk("rdata", exp_q.pop_front(), rdata);
    end
  end

  initial begin
    #100000;
    num_errors++;
    summarize();
  end

  // ****************
  // Scenarios
  // ****************
  initial begin
    rst();
    @(negedge i_clk_sys) chk("norm_n", 32'h1, norm_n);
    chk("fast_n", 32'h1, fast_n);
    for (int i = 0; i < 32; i++) begin
      seed = xs(seed);
      vec[i] = seed;
      @(posedge i_clk_sys) vwr <= {1'b1, i[4:0], seed};
    end
    @(posedge i_clk_sys) vwr.en <= 1'b0;
    prio[5] <= 3'h3;
    prio[6] <= 3'h2;
    prio[20] <= 3'h5;
    prio[11] <= 3'h7;
    rdv(32'h0);
    @(posedge i_clk_sys) per[5] <= 1'b1;
    per[6] <= 1'b1;
    tick(4);
    @(negedge i_clk_sys) chk("norm_n", 32'h0, norm_n);
    rdv(vec[5]);
    tick(2);
    @(negedge i_clk_sys) chk("depth", 32'h1, depth);
    chk("norm_n", 32'h1, norm_n);
    @(posedge i_clk_sys) per[20] <= 1'b1;
    prot <= 1'b1;
    tick(4);
    @(negedge i_clk_sys) chk("norm_n", 32'h0, norm_n);
    rdv(vec[20]);
    tick(2);
    @(negedge i_clk_sys) chk("depth", 32'h1, depth);
    // Protect mode: only the separate strobe acknowledges
    @(posedge i_clk_sys) ack <= 1'b1;
    @(posedge i_clk_sys) ack <= 1'b0;
    prot <= 1'b0;
    rdv(32'h0);
    tick(2);
    @(negedge i_clk_sys) chk("cprio", 32'h5, cprio);
    chk("depth", 32'h2, depth);
    @(posedge i_clk_sys) per[20] <= 1'b0;
    end_service();
    tick(2);
    @(negedge i_clk_sys) chk("csrc", 32'h5, csrc);
    @(posedge i_clk_sys) per[5] <= 1'b0;
    end_service();
    tick(4);
    @(negedge i_clk_sys) chk("norm_n", 32'h0, norm_n);
    rdv(vec[6]);
    @(posedge i_clk_sys) per[6] <= 1'b0;
    end_service();
    @(posedge i_clk_sys) en[11] <= 1'b0;
    per[11] <= 1'b1;
    per[15] <= 1'b1;
    per[9] <= 1'b1;
    @(posedge i_clk_sys) per[9] <= 1'b0;
    edg[9] <= 1'b1;
    tick(4);
    @(negedge i_clk_sys) chk("pend", 32'h0000_0a00, pend);
    @(posedge i_clk_sys) per[9] <= 1'b1;
    per[11] <= 1'b0;
    per[15] <= 1'b0;
    @(posedge i_clk_sys) per[9] <= 1'b0;
    tick(4);
    @(negedge i_clk_sys) chk("edge", 32'h0000_0200, pend);
    rdv(vec[9]);
    end_service();
    for (int k = 0; k < 7; k++) begin
      @(posedge i_clk_sys) sys <= 7'h1 << k;
      tick(3);
      @(negedge i_clk_sys) chk("sys", 32'h2, pend);
      @(posedge i_clk_sys) sys <= 7'h0;
      tick(3);
    end
    @(posedge i_clk_sys) fpin <= 1'b1;
    tick(5);
    // Normal request idle high, fast request low
    @(negedge i_clk_sys) chk("fpin", 32'h2, {norm_n, fast_n});
    @(posedge i_clk_sys) fpin <= 1'b0;
    ff[7] <= 1'b1;
    per[7] <= 1'b1;
    @(posedge i_clk_sys) per[7] <= 1'b0;
    tick(5);
    @(negedge i_clk_sys) chk("force", 32'h2, {norm_n, fast_n});
    @(posedge i_clk_sys) fclr <= 1'b1;
    @(posedge i_clk_sys) fclr <= 1'b0;
    tick(3);
    @(negedge i_clk_sys) chk("fclr", 32'h1, fast_n);
    for (int p = 0; p < 3; p++) begin
      for (int m = 0; m < 4; m++) begin
        @(posedge i_clk_sys) edg[29 + p] <= m[1];
        pol[29 + p] <= m[0];
        ext[p] <= ~m[0];
        rst();
        tick(4);
        @(posedge i_clk_sys) ext[p] <= m[0];
        tick(5);
        @(negedge i_clk_sys) chk("ext", 32'h1 << p, pend[31:29]);
        @(posedge i_clk_sys) ext[p] <= ~m[0];
        tick(5);
        @(negedge i_clk_sys) chk("hold", m[1], pend[29 + p]);
      end
    end
    rst();
    // Pin edge after reset ties with source 10 at level 0
    @(posedge i_clk_sys) ext <= 3'h2;
    for (int s = 0; s < 2; s++) begin
      @(posedge i_clk_sys) serve <= 1'b1;
      slow <= s[0];
      per[10] <= 1'b1;
      exp_q.push_back(vec[10]);
      tick(20);
      @(negedge i_clk_sys) chk("depth", 32'h1, depth);
      @(posedge i_clk_sys) serve <= 1'b0;
      per[10] <= 1'b0;
      end_service();
    end
    tick(4);
    chk("queue", 32'h0, exp_q.size());
    summarize();
  end
endmodule
